// *** rtl/ido_pkg.sv ***
// Operation
// R1 - Eight-bit diagnostic state register is read-only; writes change nothing.
// R2 - Bit 7 returns the serial clock input level.
// R3 - Bit 6 returns the serial data input level.
// R4 - Bit 5 returns the internal stop count signal.
// R5 - Codes 0x02 to 0x09 mark data bits 7 down to 0.
// R6 - Code 0x0A is data acknowledge; 0x0B its second half on not-acknowledge.
// R7 - Stop is generated in two states, code 0x0C then 0x0D.
// R8 - Code 0x0E is the address acknowledge, or second-byte acknowledge in 10-bit mode.
// R9 - Code 0x0F is the address read/write bit or second-byte LSB.
// R10 - Codes 0x10 to 0x17 mark first address byte bits 7 to 0.
// R11 - Code 0x18 is the acknowledge after the first 10-bit address byte.
// R12 - Codes 0x19 to 0x1F mark address bits 7 down to 1.
// R13 - Idle reports zero, start reports one.
// R14 - Software writes zero to reserved diagnostic control bits 7 to 1.
// R15 - Select bit clear: rate registers read back the reload value.
// R16 - Select bit set: rate registers read back the running counter.
// R17 - High register shows counter bits 15:8, low shows bits 7:0.
// R18 - Reading the state register has no side effects.
package ido_pkg;
   localparam int ADDR_W = 12;
   localparam logic [11:0] OFF_RATE_HIGH = 12'hF53;
   localparam logic [11:0] OFF_RATE_LOW = 12'hF54;
   localparam logic [11:0] OFF_STATE_OBSERVE = 12'hF55;
   localparam logic [11:0] OFF_COUNTER_READBACK_SELECT_SELECT = 12'hF56;
   localparam logic [7:0] RATE_BYTE_RESET = 8'hFF;
   localparam logic [7:0] COUNTER_READBACK_SELECT_SELECT_RESET = 8'h00;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;
   localparam int BIT_CLOCK = 7;
   localparam int BIT_DATA = 6;
   localparam int BIT_STOP = 5;
   localparam int BIT_SELECT = 0;

   // Transmit/receive state codes
   localparam logic [4:0] ST_IDLE = 5'h00;
   localparam logic [4:0] ST_START = 5'h01;
   localparam logic [4:0] ST_DATA7 = 5'h02;
   localparam logic [4:0] ST_DATA0 = 5'h09;
   localparam logic [4:0] ST_DATA_ACK = 5'h0A;
   localparam logic [4:0] ST_DATA_NACK = 5'h0B;
   localparam logic [4:0] ST_STOP_A = 5'h0C;
   localparam logic [4:0] ST_STOP_B = 5'h0D;
   localparam logic [4:0] ST_ADDR_ACK = 5'h0E;
   localparam logic [4:0] ST_ADDR_RW = 5'h0F;
   localparam logic [4:0] ST_FIRST7 = 5'h10;
   localparam logic [4:0] ST_FIRST0 = 5'h17;
   localparam logic [4:0] ST_FIRST_ACK = 5'h18;
   localparam logic [4:0] ST_ADDR7 = 5'h19;
   localparam logic [4:0] ST_ADDR1 = 5'h1F;

   typedef struct packed {
      logic [11:0] address;
      logic read;
      logic write;
      logic [7:0] writedata;
   } ido_req_t;

   typedef struct packed {
      logic clock_line_level;
      logic data_line_level;
      logic stop_phase_counter;
      logic [4:0] serial_fsm_state;
   } ido_observe_t;

   typedef struct packed {
      logic start;
      logic ten_bit;
      logic bit_tick;
      logic nack;
      logic more;
   } ido_step_t;
endpackage

// *** rtl/ido_sync.sv ***
`timescale 1ns/1ps
module ido_sync (
   input wire logic clock,
   input wire logic rst,
   input wire logic async_in,
   output logic sync_out
);
   logic meta_r;
   always_ff @(posedge clock) begin
      if (rst) begin
         meta_r <= 1'b1;
         sync_out <= 1'b1;
      end else begin
         meta_r <= async_in;
         sync_out <= meta_r;
      end
   end
endmodule // ido_sync

// *** rtl/ido_fsm.sv ***
`timescale 1ns/1ps
module ido_fsm (
   input wire logic clock,
   input wire logic rst,
   input wire ido_pkg::ido_step_t step,
   output logic [4:0] serial_fsm_state,
   output logic stop_phase_counter
);
   logic [4:0] state_r;
   logic [4:0] state_nxt;
   logic ten_r;
   assign serial_fsm_state = state_r;
   // Stop count high while in the stop phase
   assign stop_phase_counter = (state_r == ido_pkg::ST_STOP_A) || (state_r == ido_pkg::ST_STOP_B); // [R4]

   always_ff @(posedge clock) begin
      if (rst) ten_r <= 1'b0;
      else if (step.start && state_r == ido_pkg::ST_IDLE) ten_r <= step.ten_bit;
   end

   always_comb begin
      state_nxt = state_r;
      if (state_r == ido_pkg::ST_IDLE) begin
         if (step.start) state_nxt = ido_pkg::ST_START; // [R13]
      end else if (step.bit_tick) begin
         case (state_r)
            ido_pkg::ST_START: state_nxt = ten_r ? ido_pkg::ST_FIRST7 : ido_pkg::ST_ADDR7; // [R10] [R12]
            ido_pkg::ST_FIRST0: state_nxt = ido_pkg::ST_FIRST_ACK; // [R10]
            ido_pkg::ST_FIRST_ACK: state_nxt = step.nack ? ido_pkg::ST_STOP_A : ido_pkg::ST_ADDR7; // [R11]
            ido_pkg::ST_ADDR1: state_nxt = ido_pkg::ST_ADDR_RW; // [R12]
            ido_pkg::ST_ADDR_RW: state_nxt = ido_pkg::ST_ADDR_ACK; // [R9]
            ido_pkg::ST_ADDR_ACK: state_nxt = step.nack ? ido_pkg::ST_STOP_A : ido_pkg::ST_DATA7; // [R8]
            ido_pkg::ST_DATA0: state_nxt = ido_pkg::ST_DATA_ACK; // [R5]
            ido_pkg::ST_DATA_ACK: begin
               if (step.nack) state_nxt = ido_pkg::ST_DATA_NACK; // [R6]
               else if (step.more) state_nxt = ido_pkg::ST_DATA7;
               else state_nxt = ido_pkg::ST_STOP_A;
            end
            ido_pkg::ST_DATA_NACK: state_nxt = ido_pkg::ST_STOP_A; // [R6]
            ido_pkg::ST_STOP_A: state_nxt = ido_pkg::ST_STOP_B; // [R7]
            ido_pkg::ST_STOP_B: state_nxt = ido_pkg::ST_IDLE; // [R7] [R13]
            default: state_nxt = 5'(state_r + 5'h01); // [R5] [R10] [R12]
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (rst) state_r <= ido_pkg::ST_IDLE; // [R13]
      else state_r <= state_nxt;
   end
endmodule // ido_fsm

// *** rtl/ido_observer.sv ***
// The Avalon-MM register port was chosen for this implementation.
`timescale 1ns/1ps
module ido_observer (
   input wire logic clock,
   input wire logic rst,
   input wire logic [11:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [7:0] avs_writedata,
   output logic [7:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire ido_pkg::ido_step_t step,
   input wire logic [15:0] rate_counter,
   output logic [15:0] rate_reload_value,
   output logic counter_readback_select
);
   typedef enum logic [2:0] {
      IDO_IDLE = 3'b001,
      IDO_ANSWER = 3'b010,
      IDO_DONE = 3'b100
   } ido_bus_t;

   ido_bus_t bus_r;
   ido_pkg::ido_req_t req;
   ido_pkg::ido_observe_t obs;
   logic clock_line_level;
   logic data_line_level;
   logic [4:0] serial_fsm_state;
   logic stop_phase_counter;
   logic [7:0] rate_high_r;
   logic [7:0] rate_low_r;
   logic select_r;
   logic [7:0] read_nxt;
   logic [15:0] counter_r;

   assign req = '{address: avs_address, read: avs_read, write: avs_write,
                  writedata: avs_writedata};

   // Pins pass two flops before anything looks at them
   ido_sync u_scl (.clock(clock), .rst(rst), .async_in(scl_in), .sync_out(clock_line_level));
   ido_sync u_sda (.clock(clock), .rst(rst), .async_in(sda_in), .sync_out(data_line_level));

   ido_fsm u_fsm (
      .clock(clock),
      .rst(rst),
      .step(step),
      .serial_fsm_state(serial_fsm_state),
      .stop_phase_counter(stop_phase_counter)
   );

   assign obs = '{clock_line_level: clock_line_level, data_line_level: data_line_level,
                  stop_phase_counter: stop_phase_counter, serial_fsm_state: serial_fsm_state};

   // Counter is registered so readback is a clean snapshot
   always_ff @(posedge clock) begin
      if (rst) counter_r <= 16'h0000;
      else counter_r <= rate_counter;
   end

   always_comb begin
      read_nxt = ido_pkg::UNMAPPED_READ;
      case (req.address)
         ido_pkg::OFF_RATE_HIGH:
            read_nxt = select_r ? counter_r[15:8] : rate_high_r; // [R15] [R16] [R17]
         ido_pkg::OFF_RATE_LOW:
            read_nxt = select_r ? counter_r[7:0] : rate_low_r; // [R15] [R16] [R17]
         ido_pkg::OFF_STATE_OBSERVE: read_nxt = obs; // [R1] [R2] [R3] [R4] [R5] [R18]
         ido_pkg::OFF_COUNTER_READBACK_SELECT_SELECT: read_nxt = {7'h00, select_r};
         default: read_nxt = ido_pkg::UNMAPPED_READ;
      endcase
   end

   // One wait cycle then answer; DONE keeps a held request from repeating
   always_ff @(posedge clock) begin
      if (rst) begin
         bus_r <= IDO_IDLE;
         avs_waitrequest <= 1'b1;
         avs_readdata <= 8'h00;
      end else begin
         case (bus_r)
            IDO_IDLE: begin
               if (req.read || req.write) begin
                  bus_r <= IDO_ANSWER;
                  avs_waitrequest <= 1'b0;
                  if (req.read) avs_readdata <= read_nxt;
               end
            end
            IDO_ANSWER: begin
               bus_r <= IDO_DONE;
               avs_waitrequest <= 1'b1;
            end
            IDO_DONE: bus_r <= IDO_IDLE;
            default: begin
               bus_r <= IDO_IDLE;
               avs_waitrequest <= 1'b1;
            end
         endcase
      end
   end

   // Writes land in the answer cycle; state register ignores writes
   always_ff @(posedge clock) begin
      if (rst) begin
         rate_high_r <= ido_pkg::RATE_BYTE_RESET;
         rate_low_r <= ido_pkg::RATE_BYTE_RESET;
         select_r <= ido_pkg::COUNTER_READBACK_SELECT_SELECT_RESET[ido_pkg::BIT_SELECT];
      end else if (bus_r == IDO_ANSWER && req.write) begin // [R1]
         case (req.address)
            ido_pkg::OFF_RATE_HIGH: rate_high_r <= req.writedata;
            ido_pkg::OFF_RATE_LOW: rate_low_r <= req.writedata;
            // Reserved bits dropped; software should write them zero
            ido_pkg::OFF_COUNTER_READBACK_SELECT_SELECT: select_r <= req.writedata[ido_pkg::BIT_SELECT]; // [R14]
            default: ;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         rate_reload_value <= {ido_pkg::RATE_BYTE_RESET, ido_pkg::RATE_BYTE_RESET};
         counter_readback_select <= 1'b0;
      end else begin
         rate_reload_value <= {rate_high_r, rate_low_r};
         counter_readback_select <= select_r;
      end
   end
endmodule // ido_observer

// *** verification/ido_bus_peer.sv ***
`timescale 1ns/1ps
module ido_bus_peer (
   input wire logic [1:0] pull_low,
   output logic scl,
   output logic sda
);
   // Open-drain lines with pull-ups, so a released line reads high
   assign scl = !pull_low[1];
   assign sda = !pull_low[0];
endmodule // ido_bus_peer

// *** verification/ido_observer_properties.sv ***
`timescale 1ns/1ps
module ido_checker (
   input wire logic clock,
   input wire logic rst,
   input wire logic [11:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [7:0] avs_writedata,
   input wire logic [7:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic [15:0] rate_counter,
   input wire logic [15:0] rate_reload_value,
   input wire logic counter_readback_select
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   wire rd = !avs_waitrequest && avs_read;
   wire wr = !avs_waitrequest && avs_write;
   wire sel = counter_readback_select;
   wire [11:0] a = avs_address;
   answer_bound_a:
      assert property ((avs_read || avs_write) && avs_waitrequest |-> ##[1:4] !avs_waitrequest)
      else $error("no answer");
   answer_pulse_a:
      assert property (!avs_waitrequest |=> avs_waitrequest [*2]) else $error("answer too long");
   pin_levels_a:
      assert property (rd && a == 12'hF55 |-> avs_readdata[7:6] == {$past(scl_in, 3),
         $past(sda_in, 3)}) else $error("pin levels wrong");
   stop_flag_a:
      assert property (rd && a == 12'hF55 |-> avs_readdata[5] == (avs_readdata[4:1] == 4'h6))
      else $error("stop flag wrong");
   reload_high_a:
      assert property (rd && a == 12'hF53 && !sel |-> avs_readdata == rate_reload_value[15:8])
      else $error("reload high wrong");
   reload_low_a:
      assert property (rd && a == 12'hF54 && !sel |-> avs_readdata == rate_reload_value[7:0])
      else $error("reload low wrong");
   count_high_a:
      assert property (rd && a == 12'hF53 && sel |-> avs_readdata == $past(rate_counter[15:8], 2))
      else $error("counter high wrong");
   count_low_a:
      assert property (rd && a == 12'hF54 && sel |-> avs_readdata == $past(rate_counter[7:0], 2))
      else $error("counter low wrong");
   select_write_a:
      assert property (wr && a == 12'hF56 |-> ##2 sel == $past(avs_writedata[0], 2))
      else $error("select not written");
   cover property (rd && a == 12'hF55 && avs_readdata[4:0] == 5'h0B);
   cover property (rd && sel);
   cover property (wr && a == 12'hF55);
endmodule // ido_checker

bind ido_observer ido_checker i_chk (.clock, .rst, .avs_address, .avs_read, .avs_write,
   .avs_writedata, .avs_readdata, .avs_waitrequest, .scl_in, .sda_in, .rate_counter,
   .rate_reload_value, .counter_readback_select);

// *** verification/testbench.sv ***
`timescale 1ns/1ps
module testbench;
   logic clock = 1'b0;
   logic rst = 1'b1;
   ido_pkg::ido_req_t rq = '0;
   ido_pkg::ido_step_t st = '0;
   logic [1:0] pl = 2'h0;
   logic [15:0] cnt = 16'h0000;
   logic [7:0] rdata, q;
   logic [15:0] reload;
   logic wreq, sel, scl, sda;
   logic [31:0] seed = 32'h000007A3;
   int n_mismatch = 0;
   int comparisons = 0;
   int m_hi = 255, m_lo = 255, m_sel = 0, m_st = 0;
   always #20 clock = !clock;
   ido_bus_peer i_peer (.pull_low(pl), .scl(scl), .sda(sda));
   ido_observer i_dut (.clock(clock), .rst(rst), .avs_address(rq.address), .avs_read(rq.read),
      .avs_write(rq.write), .avs_writedata(rq.writedata), .avs_readdata(rdata),
      .avs_waitrequest(wreq), .scl_in(scl), .sda_in(sda), .step(st), .rate_counter(cnt),
      .rate_reload_value(reload), .counter_readback_select(sel));
   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // Integer model of the state walk
   function int nxt(int s, bit tb, bit nk, bit mo);
      case (s)
         1: return tb ? 16 : 25;
         24, 14: return nk ? 12 : (s == 24 ? 25 : 2);
         31: return 15;
         15: return 14;
         10: return nk ? 11 : (mo ? 2 : 12);
         13: return 0;
         default: return s + 1;
      endcase
   endfunction
   task print_verdict;
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task chk_rd(string nm, logic [7:0] e, logic [7:0] g);
      comparisons++;
      if (g !== e) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task chk_port(string nm, logic [15:0] e, logic [15:0] g);
      comparisons++;
      if (g !== e) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task xfer(bit w, logic [11:0] a, logic [7:0] d);
      int k;
      @(posedge clock);
      rq <= '{a, !w, w, d};
      k = 0;
      do begin
         @(posedge clock);
         k++;
      end while (wreq !== 1'b0 && k < 20);
      q = rdata;
      rq <= '0;
      // A hung bus ends the run here rather than stalling later tests
      if (wreq !== 1'b0) begin
         n_mismatch++;
         print_verdict();
      end
   endtask
   task wr(logic [11:0] a, logic [7:0] d);
      xfer(1'b1, a, d);
      if (a == 12'hF53) m_hi = d;
      if (a == 12'hF54) m_lo = d;
      if (a == 12'hF56) m_sel = d[0];
   endtask
   task rd(logic [11:0] a);
      logic [7:0] e;
      xfer(1'b0, a, 8'h00);
      case (a)
         12'hF53: e = m_sel ? cnt[15:8] : 8'(m_hi);
         12'hF54: e = m_sel ? cnt[7:0] : 8'(m_lo);
         12'hF55: e = {!pl[1], !pl[0], m_st == 12 || m_st == 13, 5'(m_st)};
         12'hF56: e = 8'(m_sel);
         default: e = 8'h00;
      endcase
      chk_rd("readdata", e, q);
      chk_port("reload", {8'(m_hi), 8'(m_lo)}, reload);
      chk_port("select", 16'(m_sel), {15'h0000, sel});
   endtask
   task frame(bit tb);
      logic [31:0] r;
      @(posedge clock);
      st <= '{1'b1, tb, 1'b0, 1'b0, 1'b0};
      @(posedge clock);
      st <= '0;
      m_st = 1;
      for (int k = 0; k < 200; k++) begin
         repeat (3) @(posedge clock);
         rd(12'hF55);
         rd(12'hF55);
         if (m_st == 0) break;
         r = rnd();
         pl <= r[4:3];
         @(posedge clock);
         st <= '{1'b0, tb, 1'b1, r[0] & r[1], r[2] & r[5]};
         @(posedge clock);
         st <= '0;
         m_st = nxt(m_st, tb, r[0] & r[1], r[2] & r[5]);
      end
   endtask
   initial begin
      repeat (16) @(posedge clock);
      rst <= 1'b0;
      for (int i = 0; i < 5; i++) rd(12'hF53 + 12'(i));
      $display("test reset done");
      for (int m = 0; m < 3; m++) begin
         wr(12'hF53, 8'(rnd()));
         wr(12'hF54, 8'(rnd()));
         wr(12'hF55, 8'(rnd()));
         wr(12'hF56, {7'h00, m[0]});
         cnt <= 16'(rnd());
         pl <= 2'(rnd());
         repeat (4) @(posedge clock);
         for (int i = 0; i < 5; i++) rd(12'hF53 + 12'(i));
      end
      $display("test registers done");
      for (int i = 0; i < 8; i++) frame(i[0]);
      $display("test state walk done");
      print_verdict();
   end
endmodule // testbench
